//--- logic/sgtxeb_top.sv
// transmit elastic buffer with axi4-lite registers and interrupt
`timescale 1ns/1ps
module sgtxeb_top
(
    input  wire logic                        i_clock,
    input  wire logic                        i_nrst,
    input  wire sgtxeb_pkg::sgtxeb_axi_req_t i_axi,
    output      sgtxeb_pkg::sgtxeb_axi_rsp_t o_axi,
    input  wire logic                        i_tx_frame,
    input  wire logic                        i_wr_valid,
    input  wire logic [9:0]                  i_wr_data,
    input  wire logic                        i_rd_ready,
    output logic      [9:0]                  o_rd_data,
    output logic                             o_rd_valid,
    output logic                             o_clock_gate_en,
    output logic                             o_irq
);
    import sgtxeb_pkg::*;

    sgtxeb_state_t s;
    sgtxeb_state_t next_s;
    logic [4:0]    fill;
    logic          full;
    logic          empty;
    logic          run;
    logic          wr_go;
    logic          rd_go;
    logic          ovf_ev;
    logic          unf_ev;
    logic          aw_go;
    logic          w_go;
    logic          ar_go;
    logic          do_wr;
    logic          rd_clr;
    logic [IDX_W-1:0] ar_idx;

    //==========================================================================
    // buffer condition
    assign fill   = s.wptr - s.rptr;
    assign full   = (fill == TXEB_FULL);
    assign empty  = (fill == 5'h00);
    // RULE_02: buffer works only while active
    assign run    = s.active & ~s.init;
    // RULE_10: write into a full buffer
    assign ovf_ev = run & i_wr_valid & full;
    // RULE_09: read from an empty released buffer
    assign unf_ev = run & s.released & i_rd_ready & empty;
    assign wr_go  = run & i_wr_valid & ~full;
    assign rd_go  = run & s.released & i_rd_ready & ~empty;

    //==========================================================================
    // bus handshakes
    assign aw_go  = i_axi.awvalid & ~s.aw_held;
    assign w_go   = i_axi.wvalid & ~s.w_held;
    assign ar_go  = i_axi.arvalid & ~s.rvalid;
    assign do_wr  = s.aw_held & s.w_held & ~s.bvalid;
    assign ar_idx = i_axi.araddr[ADDR_W-1:2];
    // RULE_11: status read clears flags
    assign rd_clr = ar_go & (ar_idx == IDX_STATUS);

    //==========================================================================
    // next state
    always_comb
    begin
        next_s = s;

        // RULE_03: stay active until current frame ends
        next_s.active = s.enable | (s.active & i_tx_frame);

        if (s.init)
        begin
            // RULE_06: write pointer starts at initial delay
            next_s.wptr     = {1'b0, s.wr_delay};
            // RULE_01: pointers held at initial state
            next_s.rptr     = 5'h00;
            next_s.reached  = 1'b0;
            next_s.sync     = 2'h0;
            next_s.released = 1'b0;
        end
        else
        begin
            if (wr_go)
            begin
                next_s.wptr = s.wptr + 5'h01;
            end
            if (rd_go)
            begin
                next_s.rptr = s.rptr + 5'h01;
            end
            // RULE_05: release after threshold and sync stages
            if (s.wptr[TXEB_AW-1:0] == s.rel_thr)
            begin
                next_s.reached = 1'b1;
            end
            next_s.sync     = {s.sync[0], s.reached};
            next_s.released = s.released | s.sync[TXEB_SYNC_N-1];
        end
        next_s.rd_valid = rd_go;

        // RULE_11: new fault wins over read clear
        if (rd_clr)
        begin
            next_s.ovf = 1'b0;
            next_s.unf = 1'b0;
        end
        if (ovf_ev)
        begin
            next_s.ovf = 1'b1;
        end
        if (unf_ev)
        begin
            next_s.unf = 1'b1;
        end

        // write channel capture
        if (aw_go)
        begin
            next_s.aw_held = 1'b1;
            next_s.aw_idx  = i_axi.awaddr[ADDR_W-1:2];
        end
        if (w_go)
        begin
            next_s.w_held = 1'b1;
            next_s.wdata  = i_axi.wdata;
            next_s.wstrb  = i_axi.wstrb;
        end
        if (s.bvalid && i_axi.bready)
        begin
            next_s.bvalid = 1'b0;
        end

        // register writes
        if (do_wr)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
            case (s.aw_idx)
                IDX_CONTROL:
                begin
                    if (s.wstrb[0])
                    begin
                        next_s.enable = s.wdata[ENABLE_BIT];
                        next_s.init   = s.wdata[INIT_BIT];
                    end
                end
                IDX_CONFIG:
                begin
                    if (s.wstrb[0])
                    begin
                        next_s.wr_delay = s.wdata[WDLY_MSB:WDLY_LSB];
                        next_s.rel_thr  = s.wdata[RTHR_MSB:RTHR_LSB];
                    end
                end
                IDX_STATUS:
                begin
                    next_s.bresp = RESP_OKAY;
                end
                IDX_IRQ_STAT:
                begin
                    if (s.wstrb[0])
                    begin
                        next_s.irq_st = s.irq_st & ~s.wdata[1:0];
                    end
                end
                IDX_IRQ_MASK:
                begin
                    if (s.wstrb[0])
                    begin
                        next_s.irq_mask = s.wdata[1:0];
                    end
                end
                default:
                begin
                    next_s.bresp = RESP_SLVERR;
                end
            endcase
        end

        // interrupt events, set wins over clear
        if (ovf_ev)
        begin
            next_s.irq_st[OVF_BIT] = 1'b1;
        end
        if (unf_ev)
        begin
            next_s.irq_st[UNF_BIT] = 1'b1;
        end

        // register reads
        if (s.rvalid && i_axi.rready)
        begin
            next_s.rvalid = 1'b0;
        end
        if (ar_go)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            next_s.rdata  = 32'h0000_0000;
            case (ar_idx)
                IDX_CONTROL:
                begin
                    next_s.rdata[ENABLE_BIT] = s.enable;
                    next_s.rdata[INIT_BIT]   = s.init;
                end
                IDX_CONFIG:
                begin
                    next_s.rdata[WDLY_MSB:WDLY_LSB] = s.wr_delay;
                    next_s.rdata[RTHR_MSB:RTHR_LSB] = s.rel_thr;
                end
                IDX_STATUS:
                begin
                    next_s.rdata[OVF_BIT] = s.ovf;
                    next_s.rdata[UNF_BIT] = s.unf;
                end
                IDX_IRQ_STAT:
                begin
                    next_s.rdata[1:0] = s.irq_st;
                end
                IDX_IRQ_MASK:
                begin
                    next_s.rdata[1:0] = s.irq_mask;
                end
                default:
                begin
                    next_s.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    //==========================================================================
    // registers
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s <= STATE_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    //==========================================================================
    // storage
    sgtxeb_mem
    #(
        .W     (TXEB_DATA_W),
        .DEPTH (TXEB_DEPTH),
        .AW    (TXEB_AW)
    )
    u_mem
    (
        .i_clock   (i_clock),
        .i_nrst    (i_nrst),
        .i_wr_en   (wr_go),
        .i_wr_addr (s.wptr[TXEB_AW-1:0]),
        .i_wr_data (i_wr_data),
        .i_rd_en   (rd_go),
        .i_rd_addr (s.rptr[TXEB_AW-1:0]),
        .o_rd_data (o_rd_data)
    );

    //==========================================================================
    // outputs
    assign o_axi.awready = ~s.aw_held;
    assign o_axi.wready  = ~s.w_held;
    assign o_axi.bvalid  = s.bvalid;
    assign o_axi.bresp   = s.bresp;
    assign o_axi.arready = ~s.rvalid;
    assign o_axi.rvalid  = s.rvalid;
    assign o_axi.rdata   = s.rdata;
    assign o_axi.rresp   = s.rresp;
    assign o_rd_valid    = s.rd_valid;
    // RULE_04: gate follows the active enable
    assign o_clock_gate_en = s.active;
    assign o_irq         = |(s.irq_st & s.irq_mask);

endmodule : sgtxeb_top

//--- logic/sgtxeb_pkg.sv
// constants, bus carriers and state layout of the transmit elastic buffer
//==============================================================================
// Summary of operation
// RULE_01: init bit holds buffer and pointers reset
// RULE_02: enable bit zero disables the buffer
// RULE_03: clearing enable lets current frame finish
// RULE_04: enable drives the buffer clock gate
// RULE_05: read pointer waits for threshold, then sync
// RULE_06: low config field presets the write pointer
// RULE_07: software keeps initial delay above zero
// RULE_08: software keeps initial delay below maximum
// RULE_09: underflow sets latched flag at bit one
// RULE_10: overflow sets latched flag at bit zero
// RULE_11: status read clears flags, new fault wins
package sgtxeb_pkg;

    //==========================================================================
    // buffer geometry and timing
    localparam int         TXEB_DATA_W   = 10;
    localparam int         TXEB_AW       = 4;
    localparam int         TXEB_DEPTH    = 16;
    localparam logic [4:0] TXEB_FULL     = 5'h10;
    localparam int         TXEB_SYNC_N   = 2;

    //==========================================================================
    // register indices, byte address is four times the index
    localparam int          ADDR_W        = 20;
    localparam int          IDX_W         = 18;
    localparam logic [17:0] IDX_CONTROL   = 18'h0d404;
    localparam logic [17:0] IDX_CONFIG    = 18'h0d405;
    localparam logic [17:0] IDX_STATUS    = 18'h0d406;
    localparam logic [17:0] IDX_IRQ_STAT  = 18'h0d407;
    localparam logic [17:0] IDX_IRQ_MASK  = 18'h0d408;

    //==========================================================================
    // field positions and reset values
    localparam int          ENABLE_BIT    = 0;
    localparam int          INIT_BIT      = 1;
    localparam int          WDLY_LSB      = 0;
    localparam int          WDLY_MSB      = 3;
    localparam int          RTHR_LSB      = 4;
    localparam int          RTHR_MSB      = 7;
    localparam int          OVF_BIT       = 0;
    localparam int          UNF_BIT       = 1;
    localparam logic [15:0] CTRL_RESET    = 16'h0001;
    localparam logic [15:0] CFG_RESET     = 16'h0040;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    //==========================================================================
    // axi4-lite carriers
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic              awvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [ADDR_W-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } sgtxeb_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sgtxeb_axi_rsp_t;

    //==========================================================================
    // complete state of the top module
    typedef struct packed {
        logic             enable;
        logic             init;
        logic [3:0]       rel_thr;
        logic [3:0]       wr_delay;
        logic             ovf;
        logic             unf;
        logic [1:0]       irq_st;
        logic [1:0]       irq_mask;
        logic             active;
        logic [4:0]       wptr;
        logic [4:0]       rptr;
        logic             reached;
        logic [1:0]       sync;
        logic             released;
        logic             rd_valid;
        logic             aw_held;
        logic [IDX_W-1:0] aw_idx;
        logic             w_held;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
    } sgtxeb_state_t;

    localparam sgtxeb_state_t STATE_RESET = '{
        enable   : CTRL_RESET[ENABLE_BIT],
        init     : CTRL_RESET[INIT_BIT],
        rel_thr  : CFG_RESET[RTHR_MSB:RTHR_LSB],
        wr_delay : CFG_RESET[WDLY_MSB:WDLY_LSB],
        active   : CTRL_RESET[ENABLE_BIT],
        default  : '0
    };

endpackage : sgtxeb_pkg

//--- logic/sgtxeb_mem.sv
// storage array of the transmit elastic buffer with registered read
`timescale 1ns/1ps
module sgtxeb_mem
#(
    parameter int W     = 10,
    parameter int DEPTH = 16,
    parameter int AW    = 4
)
(
    input  wire logic          i_clock,
    input  wire logic          i_nrst,
    input  wire logic          i_wr_en,
    input  wire logic [AW-1:0] i_wr_addr,
    input  wire logic [W-1:0]  i_wr_data,
    input  wire logic          i_rd_en,
    input  wire logic [AW-1:0] i_rd_addr,
    output logic      [W-1:0]  o_rd_data
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0]            rdata;
    } sgtxeb_mem_state_t;

    sgtxeb_mem_state_t s;
    sgtxeb_mem_state_t next_s;

    //==========================================================================
    // next state
    always_comb
    begin
        next_s = s;
        if (i_wr_en)
        begin
            next_s.mem[i_wr_addr] = i_wr_data;
        end
        if (i_rd_en)
        begin
            next_s.rdata = s.mem[i_rd_addr];
        end
    end

    //==========================================================================
    // registers
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_rd_data = s.rdata;

endmodule : sgtxeb_mem

//--- test/sgtxeb_top_checker.sv
// port checker of the transmit elastic buffer, bound to the top module
`timescale 1ns/1ps
module sgtxeb_top_checker
(
    input wire logic                        i_clock,
    input wire logic                        i_nrst,
    input wire sgtxeb_pkg::sgtxeb_axi_req_t i_axi,
    input wire sgtxeb_pkg::sgtxeb_axi_rsp_t o_axi,
    input wire logic                        i_tx_frame,
    input wire logic                        i_wr_valid,
    input wire logic                        i_rd_ready,
    input wire logic                        o_rd_valid,
    input wire logic                        o_clock_gate_en,
    input wire logic                        o_irq
);
    import sgtxeb_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    //==========================================================
    // sequences
    sequence s_ar_taken;
        i_axi.arvalid && o_axi.arready;
    endsequence
    sequence s_answer;
        o_axi.rvalid ##0 !o_axi.arready;
    endsequence
    sequence s_write_taken;
        i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready;
    endsequence

    //==========================================================
    // assertions
    a_gate_frame_hold: assert property (
        o_clock_gate_en && i_tx_frame |=> o_clock_gate_en)
        else $error("gate dropped during frame");
    a_gate_drop_idle: assert property (
        $fell(o_clock_gate_en) |-> !$past(i_tx_frame))
        else $error("gate dropped while frame high");
    a_gate_rise_write: assert property (
        $rose(o_clock_gate_en) |-> o_axi.bvalid || $past(o_axi.bvalid))
        else $error("gate rose without register write");
    a_read_needs_gate: assert property (
        o_rd_valid |-> $past(o_clock_gate_en))
        else $error("read while buffer disabled");
    a_read_needs_ready: assert property (
        o_rd_valid |-> $past(i_rd_ready))
        else $error("read data without request");
    a_irq_fall_write: assert property (
        $fell(o_irq) |-> $rose(o_axi.bvalid))
        else $error("irq fell without register write");
    a_irq_rise_cause: assert property (
        $rose(o_irq) |-> $past(i_wr_valid) || $past(i_rd_ready)
                         || $rose(o_axi.bvalid))
        else $error("irq rose without cause");
    a_read_answer_next: assert property (
        s_ar_taken |=> s_answer)
        else $error("read answer not one cycle later");
    a_write_answer: assert property (
        s_write_taken |=> !o_axi.bvalid ##1 o_axi.bvalid)
        else $error("write answer not two cycles after both taken");
endmodule : sgtxeb_top_checker

bind sgtxeb_top sgtxeb_top_checker i_chk (
    .i_clock         (i_clock),
    .i_nrst          (i_nrst),
    .i_axi           (i_axi),
    .o_axi           (o_axi),
    .i_tx_frame      (i_tx_frame),
    .i_wr_valid      (i_wr_valid),
    .i_rd_ready      (i_rd_ready),
    .o_rd_valid      (o_rd_valid),
    .o_clock_gate_en (o_clock_gate_en),
    .o_irq           (o_irq)
);

//--- test/sgtxeb_far_end.sv
// model of the pcs transmit logic and the serializer
`timescale 1ns/1ps
module sgtxeb_far_end
(
    input  wire logic       i_clock,
    input  wire logic       i_nrst,
    input  wire logic       i_send,
    input  wire logic       i_drain,
    output logic            o_tx_frame,
    output logic            o_wr_valid,
    output logic      [9:0] o_wr_data,
    output logic            o_rd_ready
);
    logic [9:0] cnt;

    //==========================================================
    // counting code groups, idle data toggles
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt        <= 10'h000;
            o_tx_frame <= 1'b0;
            o_wr_valid <= 1'b0;
            o_wr_data  <= 10'h000;
            o_rd_ready <= 1'b0;
        end
        else
        begin
            o_tx_frame <= i_send;
            o_wr_valid <= i_send;
            o_rd_ready <= i_drain;
            o_wr_data  <= i_send ? cnt : ~o_wr_data;
            if (i_send)
                cnt <= cnt + 10'h001;
        end
    end
endmodule : sgtxeb_far_end

//--- test/test_sgtxeb_top.sv
// self-checking bench of the transmit elastic buffer
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module test_sgtxeb_top;
    import sgtxeb_pkg::*;
    localparam logic [19:0] A_CTL = {IDX_CONTROL, 2'b00};
    localparam logic [19:0] A_CFG = {IDX_CONFIG, 2'b00};
    localparam logic [19:0] A_ST  = {IDX_STATUS, 2'b00};
    localparam logic [19:0] A_IS  = {IDX_IRQ_STAT, 2'b00};
    localparam logic [19:0] A_IM  = {IDX_IRQ_MASK, 2'b00};
    localparam logic [19:0] A_BAD = {IDX_IRQ_MASK + 18'h1, 2'b00};
    logic            i_clock;
    logic            i_nrst;
    logic            snd;
    logic            drn;
    logic            fr;
    logic            wv;
    logic            rr;
    logic            rv;
    logic            ge;
    logic            irq;
    logic [9:0]      wd;
    logic [9:0]      rd_data;
    sgtxeb_axi_req_t ax;
    sgtxeb_axi_rsp_t rs;
    int              num_errors;
    int              n_compared;
    int              nrd;
    logic [33:0]     q[$];

    sgtxeb_top i_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_axi(ax),
        .o_axi(rs), .i_tx_frame(fr), .i_wr_valid(wv), .i_wr_data(wd),
        .i_rd_ready(rr), .o_rd_data(rd_data), .o_rd_valid(rv),
        .o_clock_gate_en(ge), .o_irq(irq));
    sgtxeb_far_end i_far (.i_clock(i_clock), .i_nrst(i_nrst),
        .i_send(snd), .i_drain(drn), .o_tx_frame(fr), .o_wr_valid(wv),
        .o_wr_data(wd), .o_rd_ready(rr));

    //==========================================================
    // clock, watchdog, result monitor
    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    initial
    begin
        #400000;
        num_errors++;
        wrap_up();
    end
    always @(negedge i_clock)
    begin
        if (rs.rvalid)
        begin
            `CHK("rdata", q[0], {rs.rresp, rs.rdata})
            void'(q.pop_front());
        end
        if (rv)
        begin
            if (nrd >= 2)
                `CHK("stream", 10'(nrd - 2), rd_data)
            nrd++;
        end
    end

    //==========================================================
    // tasks
    task automatic wr(input logic [19:0] a, input logic [15:0] d,
                      input logic [1:0] e);
        logic       ha;
        logic       hw;
        logic       hb;
        logic [1:0] br;
        ax.awaddr  <= a;
        ax.awvalid <= 1'b1;
        ax.wdata   <= {16'h0000, d};
        ax.wstrb   <= 4'hf;
        ax.wvalid  <= 1'b1;
        do
        begin
            @(negedge i_clock);
            ha = ax.awvalid && rs.awready;
            hw = ax.wvalid && rs.wready;
            hb = rs.bvalid;
            br = rs.bresp;
            @(posedge i_clock);
            if (ha)
                ax.awvalid <= 1'b0;
            if (hw)
                ax.wvalid <= 1'b0;
        end
        while (!hb);
        `CHK("bresp", e, br)
    endtask : wr
    task automatic rd(input logic [19:0] a, input logic [33:0] e);
        logic ha;
        logic hb;
        q.push_back(e);
        ax.araddr  <= a;
        ax.arvalid <= 1'b1;
        do
        begin
            @(negedge i_clock);
            ha = ax.arvalid && rs.arready;
            hb = rs.rvalid;
            @(posedge i_clock);
            if (ha)
                ax.arvalid <= 1'b0;
        end
        while (!hb);
    endtask : rd
    task automatic send(input int n);
        snd <= 1'b1;
        repeat (n) @(posedge i_clock);
        snd <= 1'b0;
    endtask : send
    task automatic drain(input int n);
        repeat (n)
        begin
            drn <= 1'($urandom);
            @(posedge i_clock);
        end
        drn <= 1'b0;
    endtask : drain
    task automatic wrap_up();
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    //==========================================================
    // main sequence
    initial
    begin
        void'($urandom(6));
        i_nrst = 1'b0;
        ax = '0;
        ax.bready = 1'b1;
        ax.rready = 1'b1;
        snd = 1'b0;
        drn = 1'b0;
        nrd = 0;
        repeat (5) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        rd(A_CTL, {RESP_OKAY, 32'h00000001});
        rd(A_CFG, {RESP_OKAY, 32'h00000040});
        rd(A_ST, {RESP_OKAY, 32'h00000000});
        rd(A_BAD, {RESP_SLVERR, 32'h00000000});
        wr(A_BAD, 16'h0001, RESP_SLVERR);
        wr(A_ST, 16'h0003, RESP_OKAY);
        wr(A_CFG, 16'h0042, RESP_OKAY);
        rd(A_CFG, {RESP_OKAY, 32'h00000042});
        wr(A_CTL, 16'h0003, RESP_OKAY);
        wr(A_CTL, 16'h0001, RESP_OKAY);
        send(6);
        repeat (3) @(posedge i_clock);
        drain(60);
        repeat (3) @(posedge i_clock);
        `CHK("reads", 8, nrd)
        rd(A_ST, {RESP_OKAY, 32'h00000002});
        rd(A_ST, {RESP_OKAY, 32'h00000000});
        rd(A_IS, {RESP_OKAY, 32'h00000002});
        wr(A_IM, 16'h0003, RESP_OKAY);
        `CHK("irq", 1'b1, irq)
        wr(A_IS, 16'h0002, RESP_OKAY);
        `CHK("irq", 1'b0, irq)
        wr(A_CTL, 16'h0003, RESP_OKAY);
        drn <= 1'b1;
        send(4);
        drn <= 1'b0;
        `CHK("reads", 8, nrd)
        wr(A_CTL, 16'h0001, RESP_OKAY);
        send(16);
        repeat (3) @(posedge i_clock);
        rd(A_ST, {RESP_OKAY, 32'h00000001});
        `CHK("irq", 1'b1, irq)
        snd <= 1'b1;
        wr(A_CTL, 16'h0000, RESP_OKAY);
        `CHK("gate", 1'b1, ge)
        snd <= 1'b0;
        repeat (4) @(posedge i_clock);
        `CHK("gate", 1'b0, ge)
        drain(10);
        repeat (3) @(posedge i_clock);
        `CHK("reads", 8, nrd)
        wr(A_CTL, 16'h0001, RESP_OKAY);
        repeat (2) @(posedge i_clock);
        `CHK("gate", 1'b1, ge)
        wrap_up();
    end
endmodule : test_sgtxeb_top
